// >>> hw/cvopt_pkg.sv
// Package of offsets, field positions and reset values for the converter option and event registers.
package cvopt_pkg;
	localparam logic [7:0] ADDR_OPTION     = 8'h03;
	localparam logic [7:0] ADDR_EVENTS     = 8'h04;
	localparam int         OPT_DROOP_BIT   = 2;
	localparam int         OPT_SOLO_BIT    = 1;
	localparam int         OPT_BLANK_BIT   = 0;
	localparam logic [4:0] OPT_RSVD_RESET  = 5'h00;
	localparam logic       OPT_SOLO_RESET  = 1'h0;
	localparam logic       OPT_BLANK_RESET = 1'h0;
	localparam logic [7:0] EVENTS_RESET    = 8'h00;
	localparam int         NUM_EVENTS      = 6;
	localparam logic [1:0] EVENTS_RSVD     = 2'h0;
endpackage : cvopt_pkg

// >>> hw/cvopt_flag.sv
// One sticky event flag that sets on its event and clears when the status register is read.
`timescale 1ns/1ns
`default_nettype none
module cvopt_flag (
	input  wire logic clk,
	input  wire logic srst,
	input  wire logic event_in,
	input  wire logic read_clear,
	output var  logic flag
);
	// Set wins over the read clear so an event during the read survives for the next read.
	always_ff @(posedge clk) begin
		if (srst) begin
			flag <= 1'b0;
		end else if (event_in) begin
			flag <= 1'b1; // RULE_15
		end else if (read_clear) begin
			flag <= 1'b0; // RULE_15
		end
	end
endmodule : cvopt_flag
`default_nettype wire

// >>> hw/cvopt_regs.sv
// Option register and sticky event register of the step-down converter register bank.
// Summary of operation
// RULE_01: The host writes zero to option bits 7 to 3, which are read-write and reset to zero.
// RULE_02: Option bit 2 enables droop compensation and resets to the factory option value.
// RULE_03: Option bit 1 clear enables the enable-pin pulldown and clock-follow output, set disables both, reset zero.
// RULE_04: The host never sets the solo bit while converters run stacked.
// RULE_05: Option bit 0 set holds the good output pin released during a voltage transition, else it follows the comparator.
// RULE_06: Status bits 7 and 6 are read-only zero and software ignores them.
// RULE_07: Status bit 5 shows a retry shutdown since the last status read.
// RULE_08: Status bit 4 shows a current limit event since the last status read.
// RULE_09: Status bit 3 shows a thermal alert since the last status read.
// RULE_10: Status bit 2 shows a thermal trip since the last status read.
// RULE_11: Status bit 1 shows an undervoltage event since the last status read.
// RULE_12: Status bit 0 shows an overvoltage event since the last status read.
// RULE_13: The status register sits at address 4h and resets to zero.
// RULE_14: The option register sits at address 3h with upper nibble zero and low bits from the device option.
// RULE_15: A flag sets on its event, holds until a status read clears it, and an event during that read survives.
`timescale 1ns/1ns
`default_nettype none
module cvopt_regs #(
	parameter logic DROOP_RESET = 1'b0
) (
	input  wire logic       CLK,
	input  wire logic       SRST,
	input  wire logic [7:0] ADDR,
	input  wire logic       WR_STB,
	input  wire logic [7:0] WR_DATA,
	input  wire logic       RD_STB,
	input  wire logic [5:0] EVENTS,
	input  wire logic       WINDOW_OK,
	input  wire logic       VOLTAGE_TRANSITION,
	output var  logic [7:0] RD_DATA,
	output var  logic       DROOP_COMP_ENABLE,
	output var  logic       EN_PULLDOWN_ENABLE,
	output var  logic       CLOCK_FOLLOW_ENABLE,
	output var  logic       GOOD_OUTPUT_PIN_O,
	output var  logic       GOOD_OUTPUT_PIN_OE
);

	// Stored option fields, the sticky flags and the decode terms shared by the processes below.
	logic [4:0] opt_rsvd;
	logic       droop;
	logic       solo;
	logic       blank;
	logic [5:0] flags;
	logic       sel_opt;
	logic       sel_evt;
	logic       read_clear;
	logic [7:0] next_rd_data;

	////////////////////////////////////////////////////////////////////////////
	// Address decode for both registers.
	assign sel_opt    = (ADDR == cvopt_pkg::ADDR_OPTION); // RULE_14
	assign sel_evt    = (ADDR == cvopt_pkg::ADDR_EVENTS); // RULE_13
	assign read_clear = RD_STB && sel_evt;

	////////////////////////////////////////////////////////////////////////////
	// Option register; reserved bits are stored as written so the host can read them back.
	// Solo must stay clear in stacked setups; the logic cannot tell, so the host has to police it.
	always_ff @(posedge CLK) begin
		if (SRST) begin
			opt_rsvd <= cvopt_pkg::OPT_RSVD_RESET; // RULE_01
			droop    <= DROOP_RESET; // RULE_02
			solo     <= cvopt_pkg::OPT_SOLO_RESET; // RULE_03
			blank    <= cvopt_pkg::OPT_BLANK_RESET; // RULE_05
		end else if (WR_STB && sel_opt) begin
			opt_rsvd <= WR_DATA[7:3];
			droop    <= WR_DATA[cvopt_pkg::OPT_DROOP_BIT];
			solo     <= WR_DATA[cvopt_pkg::OPT_SOLO_BIT];
			blank    <= WR_DATA[cvopt_pkg::OPT_BLANK_BIT];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// One sticky flag per event line; bit 5 retry, 4 current, 3 alert, 2 trip, 1 under, 0 over.
	genvar gi;
	generate
		for (gi = 0; gi < cvopt_pkg::NUM_EVENTS; gi++) begin : g_flag
			cvopt_flag u_flag (
				.clk       (CLK),
				.srst      (SRST),
				.event_in  (EVENTS[gi]),
				.read_clear(read_clear),
				.flag      (flags[gi])
			); // RULE_07 RULE_08 RULE_09 RULE_10 RULE_11 RULE_12
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////
	// Read data mux; the flags are sampled before the clearing edge, so the host sees what was set.
	// A write and a read in one cycle return the old option byte, since the mux sees the stored value.
	always_comb begin
		next_rd_data = RD_DATA;
		if (RD_STB) begin
			if (sel_opt) begin
				next_rd_data = {opt_rsvd, droop, solo, blank};
			end else if (sel_evt) begin
				next_rd_data = {cvopt_pkg::EVENTS_RSVD, flags}; // RULE_06
			end else begin
				next_rd_data = 8'h00;
			end
		end
	end

	// Read data register; it only moves on a read strobe, so a slow host may pick it up late.
	always_ff @(posedge CLK) begin
		if (SRST) begin
			RD_DATA <= cvopt_pkg::EVENTS_RESET; // RULE_13
		end else begin
			RD_DATA <= next_rd_data;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs steered by option bits; the good output pin is open drain, pulled low when not good.
	// Registering the pin adds one cycle of lag behind the comparator, which is small against any ramp.
	always_ff @(posedge CLK) begin
		if (SRST) begin
			DROOP_COMP_ENABLE   <= 1'b0;
			EN_PULLDOWN_ENABLE  <= 1'b1;
			CLOCK_FOLLOW_ENABLE <= 1'b1;
			GOOD_OUTPUT_PIN_O   <= 1'b0;
			GOOD_OUTPUT_PIN_OE  <= 1'b0;
		end else begin
			DROOP_COMP_ENABLE   <= droop; // RULE_02
			EN_PULLDOWN_ENABLE  <= !solo; // RULE_03
			CLOCK_FOLLOW_ENABLE <= !solo; // RULE_03
			GOOD_OUTPUT_PIN_O   <= 1'b0;
			GOOD_OUTPUT_PIN_OE  <= !WINDOW_OK && !(blank && VOLTAGE_TRANSITION); // RULE_05
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Checks beside the logic.
	default clocking cb @(posedge CLK); endclocking
	default disable iff (SRST);

	sequence s_evt_read;
		RD_STB && sel_evt;
	endsequence

	// Bus conditions used by several properties, named so the antecedents read like the decode.
	sequence s_opt_write;
		WR_STB && sel_opt;
	endsequence

	sequence s_opt_read;
		RD_STB && sel_opt;
	endsequence

	sequence s_other_read;
		RD_STB && !sel_opt && !sel_evt;
	endsequence

	flag_survives_a: assert property (EVENTS[0] |=> flags[0]) // RULE_12
		else $error("over flag missed event");
	flag_clears_a: assert property (s_evt_read and !EVENTS[1] |=> !flags[1]) // RULE_11
		else $error("under flag not cleared");
	read_shows_a: assert property (s_evt_read |=> RD_DATA[5:0] == $past(flags)) // RULE_07
		else $error("status read wrong");
	rsvd_zero_a: assert property (s_evt_read |=> RD_DATA[7:6] == 2'h0) // RULE_06
		else $error("reserved status bits set");
	flag_holds_a: assert property (flags[4] && !read_clear |=> flags[4]) // RULE_08
		else $error("current flag dropped");
	opt_write_a: assert property (s_opt_write ##1 (RD_STB && sel_opt && !WR_STB) |=> // RULE_14
		RD_DATA == $past(WR_DATA, 2)) else $error("option readback wrong");
	solo_out_a: assert property (##1 EN_PULLDOWN_ENABLE == !$past(solo) && // RULE_03
		CLOCK_FOLLOW_ENABLE == EN_PULLDOWN_ENABLE) else $error("solo outputs wrong");
	blank_pin_a: assert property (blank && VOLTAGE_TRANSITION |=> !GOOD_OUTPUT_PIN_OE) // RULE_05
		else $error("good pin not blanked");
	droop_out_a: assert property (##1 DROOP_COMP_ENABLE == $past(droop)) // RULE_02
		else $error("droop output wrong");
	// A read in the middle cycle would clear the alert flag legally, so it is kept out of the antecedent.
	alert_set_a: assert property (EVENTS[3] ##1 (EVENTS[2] && !read_clear) |=> flags[3] && flags[2]) // RULE_09
		else $error("thermal flags lost");

	////////////////////////////////////////////////////////////////////////////
	// A write to the option address lands whole, reserved bits included, on the next edge.
	opt_lands_a: assert property (s_opt_write |=> {opt_rsvd, droop, solo, blank} == $past(WR_DATA)) // RULE_14
		else $error("option write lost");
	// Anything but an option write leaves the stored option bits alone.
	opt_keeps_a: assert property (!(WR_STB && sel_opt) |=> $stable({opt_rsvd, droop, solo, blank})) // RULE_14
		else $error("option bits changed without write");
	// Reading the option address returns the stored byte one cycle later.
	opt_read_a: assert property (s_opt_read |=> RD_DATA == $past({opt_rsvd, droop, solo, blank})) // RULE_14
		else $error("option read wrong");

	// An unmapped read returns zero rather than the last value, so stale data never leaks.
	other_read_a: assert property (s_other_read |=> RD_DATA == 8'h00) // RULE_13
		else $error("unmapped read not zero");
	// Between reads the read data stands.
	rd_stands_a: assert property (!RD_STB |=> $stable(RD_DATA)) // RULE_13
		else $error("read data moved");
	// A write to the status address changes no flag.
	evt_write_a: assert property (WR_STB && sel_evt && !RD_STB && EVENTS == 6'h00 |=> flags == $past(flags)) // RULE_13
		else $error("status write reached flags");

	// Per-flag set checks for the lines not covered above; the set wins over a read clear in
	// the same cycle, so no read term is needed.
	retry_set_a: assert property (EVENTS[5] |=> flags[5]) // RULE_07
		else $error("retry flag missed event");
	current_set_a: assert property (EVENTS[4] |=> flags[4]) // RULE_08
		else $error("current flag missed event");
	trip_set_a: assert property (EVENTS[2] |=> flags[2]) // RULE_10
		else $error("trip flag missed event");
	under_set_a: assert property (EVENTS[1] |=> flags[1]) // RULE_11
		else $error("under flag missed event");

	// A status read with no event on a line clears that line's flag.
	retry_clear_a: assert property (s_evt_read and !EVENTS[5] |=> !flags[5]) // RULE_07
		else $error("retry flag not cleared");
	trip_clear_a: assert property (s_evt_read and !EVENTS[2] |=> !flags[2]) // RULE_10
		else $error("trip flag not cleared");
	all_clear_a: assert property (s_evt_read and (EVENTS == 6'h00) |=> flags == 6'h00) // RULE_15
		else $error("flags not cleared by read");
	// No flag rises without its own event; a stuck-high line would otherwise hide here.
	no_spurious_a: assert property (##1 (flags & ~$past(flags) & ~$past(EVENTS)) == 6'h00) // RULE_15
		else $error("flag set without event");

	// Without blanking in force the good pin follows the comparator one cycle later.
	pin_follow_a: assert property (!(blank && VOLTAGE_TRANSITION) |=> // RULE_05
		GOOD_OUTPUT_PIN_OE == !$past(WINDOW_OK))
		else $error("good pin not following window");
	// A lone option write reaches the droop output two edges after its strobe.
	droop_write_a: assert property (s_opt_write ##1 !(WR_STB && sel_opt) |=> // RULE_02
		DROOP_COMP_ENABLE == $past(WR_DATA[cvopt_pkg::OPT_DROOP_BIT], 2))
		else $error("droop write not applied");

endmodule : cvopt_regs
`default_nettype wire

// >>> tb/cvopt_host.sv
// Host model that reads and writes the option and event registers one byte at a time.
`timescale 1ns/1ns
`default_nettype none
module cvopt_host (
	input  wire logic       clk,
	input  wire logic [7:0] rd_data,
	output var  logic [7:0] addr,
	output var  logic       wr_stb,
	output var  logic [7:0] wr_data,
	output var  logic       rd_stb
);
	// The bus idles with no strobe from time zero.
	initial begin
		addr = 8'h00;
		wr_stb = 1'b0;
		wr_data = 8'h00;
		rd_stb = 1'b0;
	end
	// One access per call, launched after an edge and held until the edge that takes it.
	task automatic access(input logic [7:0] a, input logic w, input logic [7:0] d, output logic [7:0] q);
		@(posedge clk);
		#1;
		addr = a;
		wr_stb = w;
		rd_stb = !w;
		wr_data = d & 8'h07;
		@(posedge clk);
		#1;
		q = rd_data;
		wr_stb = 1'b0;
		rd_stb = 1'b0;
	endtask : access
endmodule : cvopt_host
`default_nettype wire

// >>> tb/tb_top.sv
// Self-checking bench of the converter option and event registers.
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, s) begin checks_done++; if ((s) !== (e)) begin fails++; $display("wrong value %s exp %h got %h", n, e, s); end end
module tb_top;
	logic       clk = 1'b0;
	logic       srst = 1'b1;
	logic [5:0] ev = 6'h00;
	logic       wok = 1'b1;
	logic       vt = 1'b0;
	logic [7:0] addr, wd, rd, q;
	logic       ws, rs, dr, pd, cf, po, oe;
	logic [5:0] acc;
	int         fails = 0, checks_done = 0, cyc = 0, seed = 32'h637F7A13;
	cvopt_regs cvopt_regs_inst (.CLK(clk), .SRST(srst), .ADDR(addr), .WR_STB(ws), .WR_DATA(wd), .RD_STB(rs),
		.EVENTS(ev), .WINDOW_OK(wok), .VOLTAGE_TRANSITION(vt), .RD_DATA(rd), .DROOP_COMP_ENABLE(dr),
		.EN_PULLDOWN_ENABLE(pd), .CLOCK_FOLLOW_ENABLE(cf), .GOOD_OUTPUT_PIN_O(po), .GOOD_OUTPUT_PIN_OE(oe));
	cvopt_host cvopt_host_inst (.clk(clk), .rd_data(rd), .addr(addr), .wr_stb(ws), .wr_data(wd), .rd_stb(rs));
	initial begin
		forever #5 clk = ~clk;
	end
	task wr8(input logic [7:0] a, input logic [7:0] d);
		cvopt_host_inst.access(a, 1'b1, d, q);
	endtask : wr8
	task rd8(input logic [7:0] a);
		cvopt_host_inst.access(a, 1'b0, 8'h00, q);
	endtask : rd8
	// Pin is pulled low only when the window is bad and blanking is not in force.
	function logic [1:0] good_x(input logic b, input logic w, input logic t);
		return {1'b0, !w && !(b && t)};
	endfunction : good_x
	task end_of_test;
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : end_of_test
	// A hang costs a mismatch rather than an endless run.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			fails++;
			end_of_test();
		end
	end
	initial begin
		repeat (10) @(posedge clk);
		#1 srst = 1'b0;
		rd8(8'h03);
		`CHK("option", 8'h00, q)
		`CHK("pins", 4'hC, {pd, cf, dr, oe})
		rd8(8'h04);
		`CHK("status", 8'h00, q)
		$display("reset test done");
		// Every code of option bits 2 to 0, with every comparator and ramp state under it.
		for (int i = 0; i < 8; i++) begin
			wr8(8'h03, i[7:0]);
			rd8(8'h03);
			`CHK("option", i[7:0], q)
			`CHK("droop", i[2], dr)
			`CHK("pulldown", {2{!i[1]}}, {pd, cf})
			for (int j = 0; j < 4; j++) begin
				{vt, wok} = j[1:0];
				repeat (2) @(posedge clk);
				#1;
				`CHK("good pin", good_x(i[0], j[0], j[1]), {po, oe})
			end
		end
		$display("option test done");
		// Writes to the status or an unmapped place must not reach the option bits.
		wr8(8'h03, 8'h00);
		wr8(8'h04, 8'hFF);
		wr8(8'h05, 8'hFF);
		rd8(8'h03);
		`CHK("option", 8'h00, q)
		rd8(8'h05);
		`CHK("unmapped", 8'h00, q)
		for (int k = 0; k < 20; k++) begin
			acc = 6'h00;
			repeat (k % 3) begin
				ev = 6'($random(seed));
				acc |= ev;
				@(posedge clk);
				#1;
			end
			ev = 6'h00;
			rd8(8'h04);
			`CHK("flags", {2'b00, acc}, q)
		end
		// Events held through a read stay set for the next read only.
		ev = 6'h3F;
		rd8(8'h04);
		ev = 6'h00;
		`CHK("flags", 8'h3F, q)
		rd8(8'h04);
		`CHK("flags", 8'h3F, q)
		rd8(8'h04);
		`CHK("flags", 8'h00, q)
		$display("event test done");
		// A reset in mid-run must drop set flags and written options alike.
		wr8(8'h03, 8'h07);
		ev = 6'h3F;
		@(posedge clk);
		#1 ev = 6'h00;
		srst = 1'b1;
		repeat (2) @(posedge clk);
		#1 srst = 1'b0;
		rd8(8'h03);
		`CHK("option", 8'h00, q)
		`CHK("pins", 4'hC, {pd, cf, dr, oe})
		rd8(8'h04);
		`CHK("status", 8'h00, q)
		$display("second reset test done");
		end_of_test();
	end
endmodule : tb_top
`default_nettype wire
